/* wwdt_core.sv */
// module: window watchdog timing core with timed reset request
`timescale 1ns/1ps
// Summary of operation
// - window from capacitor plus ratio, or straps
// - four strapped combos: 0.25s or 2.5s
// - short window lower: 7.86ms or 2ms
// - long window lower: 78.2ms or 19.6ms
// - cap window is 6.25ms times (1+C/15.55pF)
// - cap lower boundary: window/25.8 or /64.5
// - trigger edge taken on next oscillator cycle
// - timeout asserts reset 25ms, reinitialises timer
// - lower check off until first rising edge
// - early trigger asserts reset like timeout
// - supply low holds reset, ignores trigger
module wwdt_core
  import wwdt_pkg::*;
#(
  parameter bit           CAP_MODE      = 1'b0,   // capacitor on select
  parameter bit           TIMEOUT_STRAP = 1'b0,   // time-out select level
  parameter bit           RATIO_STRAP   = 1'b0,   // ratio select level
  parameter int unsigned  CAP_FF        = 155000, // capacitance in fF
  parameter int unsigned  HOLD_CYCLES   = 32'(HOLD_CYC) // reset hold
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  supplyLow,           // undervoltage
  input  wire logic                  watchdog_trigger_in, // trigger pin
  output logic                       resetOutN,  // reset request, low
  output wwdt_pkg::wwdt_cause_t      cause,      // last violation kind
  output wwdt_pkg::wwdt_state_t      phase       // watchdog phase
);
  import wwdt_pkg::*;

  // static configuration, fixed at build time
  localparam wwdt_cfg_t CFG = '{CAP_MODE, TIMEOUT_STRAP, RATIO_STRAP};

  // capacitor-mode window in cycles
  function automatic longint unsigned cap_window(input longint unsigned ff);
    cap_window = (ff + CAP_UNIT_FF) * CAP_BASE_US * CLK_KHZ
                 / (CAP_UNIT_FF * 1000);
  endfunction : cap_window

  // upper window selection
  localparam longint unsigned UPPER_L =
    CFG.capMode ? cap_window(CAP_FF) :
    (CFG.timeoutSelect ? WIN_LONG_CYC : WIN_SHORT_CYC);
  // lower boundary selection
  localparam longint unsigned LOWER_L =
    CFG.capMode ?
      (UPPER_L * 10 / (CFG.ratioSelect ? CAP_RATIO_HI_X10
                                        : CAP_RATIO_LO_X10)) :
    CFG.timeoutSelect ?
      (CFG.ratioSelect ? LOW_LH_CYC : LOW_LS_CYC) :
      (CFG.ratioSelect ? LOW_SH_CYC : LOW_SS_CYC);

  localparam logic [CNT_W-1:0] UPPER_CYC = CNT_W'(UPPER_L);
  localparam logic [CNT_W-1:0] LOWER_CYC = CNT_W'(LOWER_L);
  localparam logic [CNT_W-1:0] HOLD_C    = CNT_W'(HOLD_CYCLES);

  logic              trigPrev_q;   // trigger level one cycle ago
  logic              rise;         // rising edge seen this cycle
  logic [CNT_W-1:0]  elapsed;      // cycles since restart last cleared it
  logic              restart;      // clear the phase counter
  logic              early;        // edge below lower boundary
  logic              late;         // upper window ran out
  wwdt_state_t       phase_d;      // next phase

  // pin is sampled each oscillator cycle, so timing is one cycle uncertain
  always_ff @(posedge clock) begin
    if (reset) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= watchdog_trigger_in;
    end
  end

  // supply low blinds the trigger entirely
  assign rise  = watchdog_trigger_in && !trigPrev_q && !supplyLow;
  assign early = (phase == WW_RUN) && rise && (elapsed < LOWER_CYC);
  assign late  = (phase != WW_HOLD) && !rise &&
                 (elapsed >= UPPER_CYC - CNT_W'(1));

  // phase transitions
  always_comb begin
    phase_d = phase;
    restart = 1'b0;
    case (phase)
      WW_HOLD: begin
        // hold stays while supply is low; leaves after the hold time
        if (supplyLow) begin
          restart = 1'b1;
        end else if (elapsed >= HOLD_C - CNT_W'(1)) begin
          phase_d = WW_FIRST;
          restart = 1'b1;
        end
      end
      WW_FIRST, WW_RUN: begin
        if (supplyLow || early || late) begin
          phase_d = WW_HOLD;
          restart = 1'b1;
        end else if (rise) begin
          phase_d = WW_RUN;
          restart = 1'b1;
        end
      end
      default: begin
        phase_d = WW_HOLD;
        restart = 1'b1;
      end
    endcase
  end

  // phase register
  always_ff @(posedge clock) begin
    if (reset) begin
      phase <= WW_HOLD;
    end else begin
      phase <= phase_d;
    end
  end

  // reset output follows the hold phase, registered
  always_ff @(posedge clock) begin
    if (reset) begin
      resetOutN <= 1'b0;
    end else begin
      resetOutN <= (phase_d != WW_HOLD);
    end
  end

  // remember why the last reset happened
  always_ff @(posedge clock) begin
    if (reset) begin
      cause <= '0;
    end else if ((phase != WW_HOLD) && (phase_d == WW_HOLD)) begin
      cause <= '{early: early, late: late};
    end
  end

  // phase timer shared by hold, first window and running window
  wwdt_counter #(
    .W (CNT_W)
  ) u_timer (
    .clock  (clock),
    .reset  (reset),
    .clear  (restart),
    .enable (1'b1),
    .count  (elapsed)
  );

endmodule : wwdt_core

/* wwdt_pkg.sv */
// package: constants, types and timing figures of the window watchdog
package wwdt_pkg;

  // clock rate of the internal oscillator model, in kHz
  localparam int unsigned CLK_KHZ = 40000;

  // strapped upper windows, in microseconds
  localparam int unsigned WIN_SHORT_US = 250000;
  localparam int unsigned WIN_LONG_US  = 2500000;

  // strapped lower boundaries, in nanoseconds
  localparam int unsigned LOW_SS_NS = 7860000;
  localparam int unsigned LOW_SH_NS = 2000000;
  localparam int unsigned LOW_LS_NS = 78200000;
  localparam int unsigned LOW_LH_NS = 19600000;

  // capacitor formula: base period in us, capacitance unit in fF
  localparam int unsigned CAP_BASE_US  = 6250;
  localparam int unsigned CAP_UNIT_FF  = 15550;
  // capacitor-mode ratios, scaled by ten
  localparam int unsigned CAP_RATIO_LO_X10 = 258;
  localparam int unsigned CAP_RATIO_HI_X10 = 645;

  // reset hold time in microseconds
  localparam int unsigned HOLD_US = 25000;
  // least trigger spacing the partner must keep, in microseconds
  localparam int unsigned MIN_SPACE_US = 500;

  // counter width, enough for the 3 s worst case at 40 MHz
  localparam int unsigned CNT_W = 32;

  // cycle counts derived from the figures above
  localparam longint unsigned WIN_SHORT_CYC = longint'(WIN_SHORT_US) * CLK_KHZ / 1000;
  localparam longint unsigned WIN_LONG_CYC  = longint'(WIN_LONG_US) * CLK_KHZ / 1000;
  localparam longint unsigned LOW_SS_CYC = longint'(LOW_SS_NS) * CLK_KHZ / 1000000;
  localparam longint unsigned LOW_SH_CYC = longint'(LOW_SH_NS) * CLK_KHZ / 1000000;
  localparam longint unsigned LOW_LS_CYC = longint'(LOW_LS_NS) * CLK_KHZ / 1000000;
  localparam longint unsigned LOW_LH_CYC = longint'(LOW_LH_NS) * CLK_KHZ / 1000000;
  localparam longint unsigned HOLD_CYC   = longint'(HOLD_US) * CLK_KHZ / 1000;

  // watchdog phases
  typedef enum logic [1:0] {
    WW_HOLD,   // reset output asserted, counting hold time
    WW_FIRST,  // first window, lower check disabled
    WW_RUN     // lower check enabled
  } wwdt_state_t;

  // configuration straps travelling together
  typedef struct packed {
    logic capMode;        // capacitor on time-out select
    logic timeoutSelect;  // strap level when not in capacitor mode
    logic ratioSelect;    // ratio strap
  } wwdt_cfg_t;

  // violation causes reported alongside reset
  typedef struct packed {
    logic early;  // trigger below lower boundary
    logic late;   // upper window expired
  } wwdt_cause_t;

endpackage : wwdt_pkg

/* wwdt_counter.sv */
// module: clearable up counter that saturates at all ones
`timescale 1ns/1ps
module wwdt_counter #(
  parameter int unsigned W = 32
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         clear,   // restart from zero
  input  wire logic         enable,  // count this cycle
  output logic     [W-1:0]  count    // elapsed cycles
);
  // saturates so a stalled phase never wraps into a false window
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      count <= '0;
    end else if (enable && (count != {W{1'b1}})) begin
      count <= count + W'(1);
    end
  end
endmodule : wwdt_counter

/* wwdt_proc_model.sv */
// supervised processor model: drives trigger pulses on request
`timescale 1ns/1ps
module wwdt_proc_model (
  input  wire logic clock,
  input  wire logic fire,  // one-cycle request for a pulse
  output logic      trig = 1'b0  // trigger pin drive
);
  int hi = 0;  // cycles of pulse left
  // pulse is high four cycles; spacing and timing are chosen by the bench
  always @(posedge clock) begin
    if (fire) hi <= 4;
    else if (hi > 0) hi <= hi - 1;
    trig <= fire || hi > 1;
  end
endmodule : wwdt_proc_model

/* wwdt_core_sva.sv */
// checker: window and hold timing seen at the core ports
`timescale 1ns/1ps
module wwdt_core_sva
  import wwdt_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 20,
  parameter int unsigned LOWER       = 80000  // lower boundary, cycles
) (
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  supplyLow,
  input wire logic                  watchdog_trigger_in,
  input wire logic                  resetOutN,
  input wire wwdt_pkg::wwdt_cause_t cause,
  input wire wwdt_pkg::wwdt_state_t phase
);
  int unsigned runCnt_q;  // cycles since run began or last edge
  int unsigned lowCnt_q;  // cycles the request has been low
  // margins of two cycles absorb the edge sampling delay
  always_ff @(posedge clock) begin
    if (reset || phase != WW_RUN || $rose(watchdog_trigger_in)) runCnt_q <= 0;
    else runCnt_q <= runCnt_q + 1;
  end
  always_ff @(posedge clock) begin
    if (reset || resetOutN) lowCnt_q <= 0;
    else lowCnt_q <= lowCnt_q + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence trigRise;
    $rose(watchdog_trigger_in) && !supplyLow;
  endsequence
  sequence held;
    phase == WW_HOLD && !resetOutN;
  endsequence
  rst_init_a: assert property (disable iff (1'b0) reset |=> held)
    else $error("reset does not enter hold");
  hold_out_a: assert property (phase == WW_HOLD |-> !resetOutN)
    else $error("hold without reset request");
  hold_len_a: assert property ($rose(resetOutN) |-> lowCnt_q >= HOLD_CYCLES - 2)
    else $error("reset request too short");
  hold_first_a: assert property ($rose(resetOutN) |-> phase == WW_FIRST)
    else $error("release not into first window");
  supply_hold_a: assert property (supplyLow |=> held)
    else $error("supply low not holding reset");
  first_lower_a: assert property (phase == WW_FIRST ##0 trigRise |=> phase == WW_RUN && resetOutN)
    else $error("first edge not accepted");
  early_viol_a: assert property (phase == WW_RUN && runCnt_q + 2 < LOWER ##0 trigRise |=> held ##0 cause.early)
    else $error("early edge not flagged");
  in_window_a: assert property (phase == WW_RUN && runCnt_q > LOWER + 2 ##0 trigRise |=> phase == WW_RUN && resetOutN)
    else $error("valid edge refused");
endmodule : wwdt_core_sva
bind wwdt_core wwdt_core_sva #(.HOLD_CYCLES(HOLD_CYCLES),
  .LOWER(LOWER_CYC))
  i_sva (.clock(clock), .reset(reset), .supplyLow(supplyLow),
  .watchdog_trigger_in(watchdog_trigger_in), .resetOutN(resetOutN),
  .cause(cause), .phase(phase));

/* tb_window_watchdog_timing.sv */
// testbench: watchdog core against a small behavioural model
`timescale 1ns/1ps
module tb_window_watchdog_timing;
  import wwdt_pkg::*;
  localparam int unsigned HOLD = 20;  // shortened hold keeps the run short
  localparam int unsigned LOW  = 32'(LOW_SH_CYC);  // short window, ratio high
  // capacitor kept at the smallest supported value; strap mode is used
  localparam int unsigned CAP_FF = 155000;
  logic        clock = 1'b0, reset = 1'b1, supplyLow = 1'b0, fire = 1'b0;
  logic        trig, resetOutN;  // trigger pin, active-low request
  wwdt_cause_t cause;
  wwdt_state_t phase;
  int          n_mismatch = 0, n_checks = 0, gap;
  always #12.5 clock = ~clock;
  wwdt_proc_model i_proc (.clock(clock), .fire(fire), .trig(trig));
  wwdt_core #(.RATIO_STRAP(1'b1), .CAP_FF(CAP_FF), .HOLD_CYCLES(HOLD))
    i_dut (.clock(clock),
    .reset(reset), .supplyLow(supplyLow), .watchdog_trigger_in(trig),
    .resetOutN(resetOutN), .cause(cause), .phase(phase));
  // model: an edge before the lower boundary ends the run phase
  function automatic wwdt_state_t judge(int unsigned elapsed);
    return (elapsed < LOW) ? WW_HOLD : WW_RUN;
  endfunction : judge
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic st(input logic n, input wwdt_state_t p);
    chk(4'({resetOutN, phase}), 4'({n, p}));
  endtask : st
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // request one pulse and let the model finish it
  task automatic pulse;
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse
  // bounded wait for release; a hang ends the run
  task automatic wait_rel;
    int n;
    for (n = 0; n < HOLD + 40 && resetOutN !== 1'b1; n++) @(posedge clock);
    chk(4'(n >= HOLD - 4), 4'h1);
    if (resetOutN !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask : wait_rel
  initial begin
    void'($urandom(6630));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    st(1'b0, WW_HOLD);
    chk(4'(cause), 4'h0);
    wait_rel();
    st(1'b1, WW_FIRST);
    pulse();
    st(1'b1, WW_RUN);
    $display("test first window done");
    gap = 20400 + $urandom % 400;
    repeat (gap) @(posedge clock);
    pulse();
    st(1'b0, judge(gap));
    chk(4'(cause), 4'h2);
    wait_rel();
    st(1'b1, WW_FIRST);
    $display("test early edge done");
    supplyLow <= 1'b1;
    pulse();
    st(1'b0, WW_HOLD);
    chk(4'(cause), 4'h0);
    supplyLow <= 1'b0;
    wait_rel();
    st(1'b1, WW_FIRST);
    $display("test supply low done");
    pulse();
    gap = LOW + 100 + $urandom % 400;
    repeat (gap) @(posedge clock);
    pulse();
    st(1'b1, judge(gap));
    $display("test valid edge done");
    end_sim();
  end
endmodule : tb_window_watchdog_timing
